// *** rtl/mfb_consts.svh ***
`ifndef MFB_CONSTS_SVH
`define MFB_CONSTS_SVH

// Clocks
`define CLK_HZ 100000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define LINK_PERIOD_NS 160

// Register byte offsets
`define REG_CTRL 5'h00
`define REG_CFG 5'h04
`define REG_OFFSET 5'h08
`define REG_STATUS 5'h0C
`define REG_POS 5'h10
`define REG_SPEED 5'h14

// Control fields
`define CTRL_FB_LSB 0
`define CTRL_MODE_LSB 2
`define CTRL_POWER_BIT 4
`define CTRL_IDXCLR_BIT 5

// Feedback types
`define FB_HALL 2'h0
`define FB_INCR_HALL 2'h1
`define FB_INCR_ONLY 2'h2
`define FB_SSI 2'h3

// Control types
`define MODE_TORQUE 2'h0
`define MODE_SPEED 2'h1
`define MODE_POS 2'h2

// Frame configuration fields and reset values
`define CFG_ST_LSB 0
`define CFG_MT_LSB 8
`define CFG_ST_RESET 6'h10
`define CFG_MT_RESET 6'h0D
`define SSI_MAX_BITS 6'h20

// Status fields
`define STAT_FAULT_BIT 3
`define STAT_IDX_BIT 4
`define STAT_ALIGN_BIT 5
`define STAT_RUN_BIT 6
`define STAT_POSEN_BIT 7
`define STAT_VALID_BIT 8
`define STAT_BUSY_BIT 9

// Timing
`define ALIGN_TIME_MS 500
`define SPEED_WIN_MS 1
`define SSI_MONO_NS 20000
`define SSI_MONO_CYC \
    ((`SSI_MONO_NS + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS)

`endif

// *** rtl/mfb_pkg.sv ***
package mfb_pkg;

    typedef enum logic [1:0] {PWR_OFF, PWR_ALIGN, PWR_RUN} pwr_state_t;

    typedef enum logic [2:0] {
        LNK_IDLE, LNK_LOW, LNK_HIGH, LNK_TAIL1, LNK_TAIL2, LNK_MONO
    } lnk_state_t;

    typedef struct packed {
        logic rst_m;
        logic rst_s;
        logic ce_m;
        logic ce_s;
        logic req_m;
        logic req_s;
        logic req_seen;
        logic dat_m;
        logic dat_s;
        lnk_state_t st;
        logic [5:0] left;
        logic first;
        logic [6:0] mono;
        logic [31:0] shreg;
        logic done_tgl;
        logic [31:0] word;
        logic sclk;
    } link_state_t;

    typedef struct packed {
        logic [1:0] fb;
        logic [1:0] mode;
        logic power;
        logic [5:0] st_cfg;
        logic [5:0] mt_cfg;
        logic [31:0] offset;
        logic wait_r;
        logic [31:0] rdata;
        logic [2:0] h_m;
        logic [2:0] h_s;
        logic [2:0] e_m;
        logic [2:0] e_s;
        logic [2:0] e_p;
        logic [2:0] rep;
        logic [2:0] sector;
        logic hall_fault;
        logic idx_seen;
        logic [31:0] enc_cnt;
        logic [31:0] win_cnt;
        logic [31:0] last_cnt;
        logic [31:0] speed;
        pwr_state_t pst;
        logic [31:0] align_cnt;
        logic run;
        logic align;
        logic pos_en;
        logic spd_en;
        logic trq_en;
        logic req_tgl;
        logic [5:0] nbits;
        logic busy;
        logic done_m;
        logic done_s;
        logic done_seen;
        logic abs_valid;
        logic [31:0] pos;
        logic [5:0] lrst_cnt;
    } top_state_t;

endpackage

// *** rtl/ssi_link_if.sv ***
interface ssi_link_if;
    logic req_tgl;
    logic [5:0] nbits;
    logic done_tgl;
    logic [31:0] word;

    modport sys (output req_tgl, output nbits,
                 input done_tgl, input word);
    modport link (input req_tgl, input nbits,
                  output done_tgl, output word);
endinterface

// *** rtl/ssi_link.sv ***
`include "mfb_consts.svh"

module ssi_link (
    // Link clock and system-side controls
    input wire logic clk_link,
    input wire logic rst_n,
    input wire logic ce,
    // Request and result
    ssi_link_if.link lnk,
    // Encoder pins
    input wire logic abs_serial_data,
    output logic abs_serial_clock_pos
);
    import mfb_pkg::*;

    link_state_t q;
    link_state_t d;

    always_comb begin
        d = q;
        d.rst_m = rst_n;
        d.rst_s = q.rst_m;
        d.ce_m = ce;
        d.ce_s = q.ce_m;
        d.req_m = lnk.req_tgl;
        d.req_s = q.req_m;
        d.dat_m = abs_serial_data;
        d.dat_s = q.dat_m;
        if (!q.rst_s) begin
            d.req_seen = 1'b0;
            d.st = LNK_IDLE;
            d.left = 6'h00;
            d.first = 1'b1;
            d.mono = 7'h00;
            d.shreg = 32'h0;
            d.done_tgl = 1'b0;
            d.word = 32'h0;
            d.sclk = 1'b1;
        end else if (q.ce_s) begin
            unique case (q.st)
                LNK_IDLE: begin
                    if (q.req_s != q.req_seen) begin
                        d.req_seen = q.req_s;
                        d.left = lnk.nbits;
                        d.first = 1'b1;
                        d.shreg = 32'h0;
                        d.sclk = 1'b0;
                        d.st = LNK_LOW;
                    end
                end
                LNK_LOW: begin
                    d.sclk = 1'b1;
                    d.left = q.left - 6'h01;
                    d.st = LNK_HIGH;
                end
                LNK_HIGH: begin
                    // Synced data shows the bit sent one period earlier
                    if (!q.first) begin
                        d.shreg = {q.shreg[30:0], q.dat_s};
                    end
                    d.first = 1'b0;
                    if (q.left == 6'h00) begin
                        d.st = LNK_TAIL1;
                    end else begin
                        d.sclk = 1'b0;
                        d.st = LNK_LOW;
                    end
                end
                LNK_TAIL1: begin
                    d.st = LNK_TAIL2;
                end
                LNK_TAIL2: begin
                    d.word = {q.shreg[30:0], q.dat_s};
                    d.done_tgl = ~q.done_tgl;
                    d.mono = 7'(`SSI_MONO_CYC);
                    d.st = LNK_MONO;
                end
                LNK_MONO: begin
                    d.mono = q.mono - 7'h01;
                    if (q.mono == 7'h01) begin
                        d.st = LNK_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_link) begin
        q <= d;
    end

    assign lnk.done_tgl = q.done_tgl;
    assign lnk.word = q.word;
    assign abs_serial_clock_pos = q.sclk;

    // Rising edges of the serial clock within the current frame
    logic [5:0] pulses_q;
    always_ff @(posedge clk_link) begin
        if (q.st == LNK_IDLE) begin
            pulses_q <= 6'h00;
        end else if (!q.sclk && d.sclk) begin
            pulses_q <= pulses_q + 6'h01;
        end
    end

    AST_SSI_IDLE_HIGH: assert property (
        @(posedge clk_link) disable iff (!q.rst_s)
        (q.st == LNK_IDLE || q.st == LNK_MONO) |-> q.sclk)
        else $error("serial clock not high between frames");

    AST_SSI_PULSES: assert property (
        @(posedge clk_link) disable iff (!q.rst_s)
        q.st == LNK_TAIL2 |-> pulses_q == lnk.nbits)
        else $error("frame clock pulse count differs from bit count");

endmodule // ssi_link

// *** rtl/motor_feedback_interface.sv ***
`include "mfb_consts.svh"

module motor_feedback_interface #(
    parameter int unsigned ALIGN_CYCLES = `ALIGN_TIME_MS * `CYC_PER_MS,
    parameter int unsigned SPEED_CYCLES = `SPEED_WIN_MS * `CYC_PER_MS
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Motor sensors
    input wire logic hall_input_a,
    input wire logic hall_input_b,
    input wire logic hall_input_c,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_z,
    // Absolute encoder link
    input wire logic clk_link,
    input wire logic abs_serial_data,
    output logic abs_serial_clock_pos,
    // Repeated encoder channels
    output logic enc_rep_a,
    output logic enc_rep_b,
    output logic enc_rep_z,
    // Feedback and drive status
    output logic [2:0] hall_sector,
    output logic [31:0] shaft_position,
    output logic [31:0] shaft_speed,
    output logic align_active,
    output logic power_run,
    output logic pos_reg_en,
    output logic speed_reg_en,
    output logic torque_reg_en
);
    import mfb_pkg::*;

    top_state_t q;
    top_state_t d;
    ssi_link_if lnk ();

    logic [31:0] be_mask;
    genvar g;
    for (g = 0; g < 4; g++) begin : g_be
        assign be_mask[8*g +: 8] = {8{avs_byteenable[g]}};
    end

    function automatic logic [3:0] hall_decode(input logic [2:0] h);
        unique case (h)
            3'b001: hall_decode = 4'h0;
            3'b011: hall_decode = 4'h1;
            3'b010: hall_decode = 4'h2;
            3'b110: hall_decode = 4'h3;
            3'b100: hall_decode = 4'h4;
            3'b101: hall_decode = 4'h5;
            default: hall_decode = 4'h8;
        endcase
    endfunction

    always_comb begin
        logic [31:0] image;
        logic [31:0] wr;
        logic [3:0] hd;
        logic step;
        logic [6:0] total;
        logic [31:0] src;
        image = 32'h0;
        wr = 32'h0;
        hd = 4'h0;
        step = 1'b0;
        total = 7'h00;
        src = 32'h0;
        d = q;
        if (!rst_n) begin
            d = '0;
            d.st_cfg = `CFG_ST_RESET;
            d.mt_cfg = `CFG_MT_RESET;
            d.wait_r = 1'b1;
            d.pst = PWR_OFF;
        end else if (ce) begin
            d.h_m = {hall_input_c, hall_input_b, hall_input_a};
            d.h_s = q.h_m;
            d.e_m = {enc_z, enc_b, enc_a};
            d.e_s = q.e_m;
            d.e_p = q.e_s;
            d.rep = q.e_s;
            d.done_m = lnk.done_tgl;
            d.done_s = q.done_m;
            // Link reset outlasts a short system reset by 32 cycles
            if (!q.lrst_cnt[5]) begin
                d.lrst_cnt = q.lrst_cnt + 6'h01;
            end

            // Register read image
            unique case (avs_address)
                `REG_CTRL: image = {27'h0, q.power, q.mode, q.fb};
                `REG_CFG: image = {18'h0, q.mt_cfg, 2'h0, q.st_cfg};
                `REG_OFFSET: image = q.offset;
                `REG_STATUS: image = {22'h0, q.busy, q.abs_valid,
                    q.pos_en, q.run, q.align, q.idx_seen, q.hall_fault,
                    q.sector};
                `REG_POS: image = q.pos;
                `REG_SPEED: image = q.speed;
                default: image = 32'h0;
            endcase
            wr = (image & ~be_mask) | (avs_writedata & be_mask);

            // Bus handshake: one wait cycle, then answer
            if ((avs_read || avs_write) && q.wait_r) begin
                d.wait_r = 1'b0;
                d.rdata = avs_read ? image : 32'h0;
            end else begin
                d.wait_r = 1'b1;
            end

            // Index flag: a zero pulse beats a clear in the same cycle
            if (avs_write && !q.wait_r && avs_address == `REG_CTRL
                && wr[`CTRL_IDXCLR_BIT]) begin
                d.idx_seen = 1'b0;
            end
            if (q.e_s[2] && !q.e_p[2]) begin
                d.idx_seen = 1'b1;
            end

            if (avs_write && !q.wait_r) begin
                unique case (avs_address)
                    `REG_CTRL: begin
                        d.fb = wr[`CTRL_FB_LSB +: 2];
                        d.mode = wr[`CTRL_MODE_LSB +: 2];
                        d.power = wr[`CTRL_POWER_BIT];
                    end
                    `REG_CFG: begin
                        d.st_cfg = wr[`CFG_ST_LSB +: 6];
                        d.mt_cfg = wr[`CFG_MT_LSB +: 6];
                    end
                    `REG_OFFSET: d.offset = wr;
                    default: ;
                endcase
            end

            // Hall commutation, ignored when the sensors are not fitted
            hd = hall_decode(q.h_s);
            if (q.fb == `FB_HALL || q.fb == `FB_INCR_HALL) begin
                d.sector = hd[2:0];
                d.hall_fault = hd[3];
            end else begin
                d.sector = 3'h0;
                d.hall_fault = 1'b0;
            end

            // Quadrature decode
            step = q.e_s[0] ^ q.e_p[0] ^ q.e_s[1] ^ q.e_p[1];
            if (step) begin
                d.enc_cnt = (q.e_s[0] ^ q.e_p[1]) ? q.enc_cnt + 32'h1
                                                  : q.enc_cnt - 32'h1;
            end

            // Absolute frame request and capture
            total = {1'b0, q.st_cfg} + {1'b0, q.mt_cfg};
            if (q.fb == `FB_SSI && !q.busy) begin
                d.req_tgl = ~q.req_tgl;
                d.busy = 1'b1;
                d.nbits = (total > 7'h20) ? `SSI_MAX_BITS :
                          (total == 7'h00) ? 6'h01 : total[5:0];
            end
            if (q.busy && q.done_s != q.done_seen) begin
                d.done_seen = q.done_s;
                d.busy = 1'b0;
                d.abs_valid = 1'b1;
                d.pos = lnk.word + q.offset;
            end
            if (q.fb != `FB_SSI) begin
                d.pos = q.enc_cnt;
            end

            // Speed over a fixed window
            src = (q.fb == `FB_SSI) ? q.pos : q.enc_cnt;
            if (q.win_cnt == 32'(SPEED_CYCLES - 1)) begin
                d.win_cnt = 32'h0;
                d.speed = src - q.last_cnt;
                d.last_cnt = src;
            end else begin
                d.win_cnt = q.win_cnt + 32'h1;
            end

            // Power stage sequencing
            unique case (q.pst)
                PWR_OFF: begin
                    if (q.power) begin
                        d.align_cnt = 32'h0;
                        d.pst = (q.fb == `FB_INCR_ONLY) ? PWR_ALIGN
                                                        : PWR_RUN;
                    end
                end
                PWR_ALIGN: begin
                    if (!q.power) begin
                        d.pst = PWR_OFF;
                    end else if (q.align_cnt ==
                                 32'(ALIGN_CYCLES - 1)) begin
                        d.pst = PWR_RUN;
                    end else begin
                        d.align_cnt = q.align_cnt + 32'h1;
                    end
                end
                PWR_RUN: begin
                    if (!q.power) begin
                        d.pst = PWR_OFF;
                    end
                end
            endcase
            d.align = d.pst == PWR_ALIGN;
            d.run = d.pst == PWR_RUN;
            d.pos_en = d.run && d.mode == `MODE_POS;
            d.spd_en = d.run && d.mode != `MODE_TORQUE;
            d.trq_en = d.run;
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    assign lnk.req_tgl = q.req_tgl;
    assign lnk.nbits = q.nbits;

    ssi_link u_link (
        .clk_link(clk_link),
        .rst_n(q.lrst_cnt[5]),
        .ce(ce),
        .lnk(lnk),
        .abs_serial_data(abs_serial_data),
        .abs_serial_clock_pos(abs_serial_clock_pos)
    );

    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wait_r;
    assign {enc_rep_z, enc_rep_b, enc_rep_a} = q.rep;
    assign hall_sector = q.sector;
    assign shaft_position = q.pos;
    assign shaft_speed = q.speed;
    assign align_active = q.align;
    assign power_run = q.run;
    assign pos_reg_en = q.pos_en;
    assign speed_reg_en = q.spd_en;
    assign torque_reg_en = q.trq_en;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_hall_011;
        (ce && (q.fb == `FB_HALL || q.fb == `FB_INCR_HALL)
         && {hall_input_c, hall_input_b, hall_input_a} == 3'b011) [*3];
    endsequence
    sequence s_switch_on;
        ce && q.pst == PWR_OFF && q.power && q.fb == `FB_INCR_ONLY;
    endsequence
    sequence s_aligning;
        align_active && !power_run && !pos_reg_en;
    endsequence

    AST_HALL_SECTOR: assert property (
        s_hall_011 |=> hall_sector == 3'h1)
        else $error("hall code 011 did not give sector 1");

    AST_SPEED_WINDOW: assert property (
        ce && q.fb != `FB_SSI && q.win_cnt == 32'(SPEED_CYCLES - 1)
        |=> shaft_speed == $past(q.enc_cnt) - $past(q.last_cnt))
        else $error("speed is not the encoder count over the window");

    AST_ALIGN_START: assert property (
        s_switch_on |=> s_aligning)
        else $error("switch-on without alignment");

    AST_ALIGN_END: assert property (
        ce && q.power && q.pst == PWR_ALIGN
        && q.align_cnt == 32'(ALIGN_CYCLES - 1) |=> power_run)
        else $error("alignment did not end in run");

    AST_POS_REG: assert property (
        pos_reg_en |-> power_run && q.mode == `MODE_POS && torque_reg_en)
        else $error("position regulator enabled outside position mode");

    AST_SSI_ONLY: assert property (
        q.fb != `FB_SSI && !q.busy |=> $stable(q.req_tgl))
        else $error("serial frame requested in a non-absolute mode");

    AST_REPEAT: assert property (
        ce ##1 ce ##1 ce |=> {enc_rep_z, enc_rep_b, enc_rep_a}
            == $past({enc_z, enc_b, enc_a}, 3))
        else $error("repeated encoder channels do not follow the inputs");

    AST_NO_HALL: assert property (
        (q.fb == `FB_INCR_ONLY || q.fb == `FB_SSI) ##1 ce
        |-> !q.hall_fault && hall_sector == 3'h0)
        else $error("absent hall sensors flagged");

    AST_ABS_OFFSET: assert property (
        ce && q.busy && q.done_s != q.done_seen && q.fb == `FB_SSI
        |=> shaft_position == $past(lnk.word) + $past(q.offset))
        else $error("absolute position lacks the offset");

endmodule // motor_feedback_interface

// *** verif/ssi_encoder_model.sv ***
module ssi_encoder_model (
    // Link side
    input wire logic clk_link,
    input wire logic sclk,
    // Position to report
    input wire logic [5:0] nbits,
    input wire logic [31:0] value,
    // Data pin
    output logic sdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    int idle = 0;
    initial sdata = 1'b1;
    // Next bit on every falling clock edge, pull-up level past the end
    always @(negedge sclk) begin
        sdata <= (cnt < nbits) ? value[nbits - 1 - cnt] : 1'b1;
        cnt <= cnt + 1;
    end
    // Clock high for a while ends the frame
    always @(posedge clk_link) begin
        idle <= sclk ? idle + 1 : 0;
        if (idle == 3) begin
            cnt <= 0;
            sdata <= 1'b1;
        end
    end
endmodule // ssi_encoder_model

// *** verif/motor_feedback_interface_bench.sv ***
`include "mfb_consts.svh"
`define CHK(got, exp, msg) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("wrong value at %0t: %s", $time, msg); \
        end \
    end

module motor_feedback_interface_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned ALIGN = 20;
    localparam int unsigned SPW = 16;
    logic clk_sys = 0;
    logic clk_link = 0;
    logic rst_n = 0;
    logic [4:0] avs_address = 0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic hall_input_a = 1;
    logic hall_input_b = 0;
    logic hall_input_c = 0;
    logic enc_a = 0;
    logic enc_b = 0;
    logic enc_z = 0;
    logic abs_serial_data;
    logic abs_serial_clock_pos;
    logic enc_rep_a, enc_rep_b, enc_rep_z;
    logic [2:0] hall_sector;
    logic [31:0] shaft_position, shaft_speed;
    logic align_active, power_run, pos_reg_en, speed_reg_en, torque_reg_en;
    logic [5:0] nbits = 6'h08;
    logic [31:0] value = 0;
    int err_total = 0;
    int cmp_count = 0;

    initial forever #5 clk_sys = ~clk_sys;
    initial begin
        #3;
        forever #80 clk_link = ~clk_link;
    end

    motor_feedback_interface #(.ALIGN_CYCLES(ALIGN), .SPEED_CYCLES(SPW))
    motor_feedback_interface_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hall_input_a(hall_input_a),
        .hall_input_b(hall_input_b), .hall_input_c(hall_input_c),
        .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z), .clk_link(clk_link),
        .abs_serial_data(abs_serial_data),
        .abs_serial_clock_pos(abs_serial_clock_pos), .enc_rep_a(enc_rep_a),
        .enc_rep_b(enc_rep_b), .enc_rep_z(enc_rep_z),
        .hall_sector(hall_sector), .shaft_position(shaft_position),
        .shaft_speed(shaft_speed), .align_active(align_active),
        .power_run(power_run), .pos_reg_en(pos_reg_en),
        .speed_reg_en(speed_reg_en), .torque_reg_en(torque_reg_en));

    ssi_encoder_model ssi_encoder_model_inst (.clk_link(clk_link),
        .sclk(abs_serial_clock_pos), .nbits(nbits), .value(value),
        .sdata(abs_serial_data));

    function automatic logic [2:0] hall_code(int s);
        logic [2:0] t [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
        return t[s];
    endfunction

    function automatic logic [31:0] abs_word(logic [31:0] v, int n);
        return (n == 32) ? v : v & ((32'h1 << n) - 32'h1);
    endfunction

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic frame(output int p);
        logic prev;
        p = 0;
        @(negedge abs_serial_clock_pos);
        prev = 1'b0;
        repeat (100) begin
            @(posedge clk_link);
            if (!prev && abs_serial_clock_pos === 1'b1)
                p++;
            prev = abs_serial_clock_pos;
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end

    initial begin
        logic [31:0] q, p0, d, off;
        int s, n, st, mt, p;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        void'($urandom(58070));
        bus(1'b0, `REG_CFG, 0, q);
        `CHK(q, {18'h0, `CFG_MT_RESET, 2'h0, `CFG_ST_RESET}, "cfg")
        bus(1'b0, 5'h18, 0, q);
        `CHK(q, 32'h0, "unmapped read")
        $display("test registers done");
        wr(`REG_CTRL, 32'h4);
        for (int i = 0; i < 12; i++) begin
            if (i == 6)
                wr(`REG_CTRL, 32'h5);
            s = (i == 0) ? 1 : $urandom % 6;
            {hall_input_c, hall_input_b, hall_input_a} <= hall_code(s);
            repeat (6) @(posedge clk_sys);
            `CHK(hall_sector, 3'(s), "sector")
        end
        {hall_input_c, hall_input_b, hall_input_a} <= 3'h0;
        repeat (6) @(posedge clk_sys);
        bus(1'b0, `REG_STATUS, 0, q);
        `CHK(q[`STAT_FAULT_BIT], 1'b1, "hall fault")
        {hall_input_c, hall_input_b, hall_input_a} <= 3'h1;
        $display("test hall done");
        for (int i = 0; i < 8; i++) begin
            q = $urandom;
            {enc_z, enc_b, enc_a} <= q[2:0];
            repeat (5) @(posedge clk_sys);
            `CHK({enc_rep_z, enc_rep_b, enc_rep_a}, q[2:0], "repeat")
        end
        enc_z <= 1'b1;
        repeat (5) @(posedge clk_sys);
        {enc_z, enc_b, enc_a} <= 3'h0;
        bus(1'b0, `REG_STATUS, 0, q);
        `CHK(q[`STAT_IDX_BIT], 1'b1, "index set")
        wr(`REG_CTRL, 32'h25);
        bus(1'b0, `REG_STATUS, 0, q);
        `CHK(q[`STAT_IDX_BIT], 1'b0, "index clear")
        $display("test repeat done");
        repeat (6) @(posedge clk_sys);
        p0 = shaft_position;
        n = 4 + $urandom % 20;
        for (int i = 1; i <= n; i++) begin
            q = {30'h0, 2'(i % 4)};
            {enc_b, enc_a} <= q[1] ? {1'b1, ~q[0]} : {1'b0, q[0]};
            if (i == n / 2)
                {hall_input_c, hall_input_b, hall_input_a} <= hall_code(3);
            repeat (4) @(posedge clk_sys);
        end
        repeat (3 * SPW + 10) @(posedge clk_sys);
        d = shaft_position - p0;
        `CHK(d == n || d == -n, 1'b1, "encoder count")
        `CHK(shaft_speed, 32'h0, "speed at rest")
        $display("test encoder done");
        for (int m = 0; m < 3; m++) begin
            wr(`REG_CTRL, 32'h11 | (m << 2));
            repeat (3) @(posedge clk_sys);
            `CHK(power_run && !align_active, 1'b1, "run")
            `CHK(pos_reg_en, 1'(m == 2), "pos enable")
            `CHK(speed_reg_en, 1'(m != 0), "speed enable")
            `CHK(torque_reg_en, 1'b1, "torque enable")
            wr(`REG_CTRL, 32'h1);
            repeat (2) @(posedge clk_sys);
            `CHK(power_run, 1'b0, "off")
        end
        repeat (2) begin
            // No brake, no vertical axis: incremental only allowed
            wr(`REG_CTRL, 32'h1A);
            repeat (2) @(posedge clk_sys);
            `CHK({align_active, power_run}, 2'b10, "aligning")
            repeat (ALIGN + 4) @(posedge clk_sys);
            `CHK({align_active, power_run}, 2'b01, "aligned")
            wr(`REG_CTRL, 32'h2);
            repeat (2) @(posedge clk_sys);
        end
        $display("test power done");
        for (int k = 0; k < 3; k++) begin
            st = (k == 2) ? 16 : 4 + $urandom % 12;
            mt = (k == 2) ? 16 : 1 + $urandom % 8;
            off = $urandom;
            value <= $urandom;
            nbits <= 6'(st + mt);
            wr(`REG_CFG, (mt << 8) | st);
            wr(`REG_OFFSET, off);
            wr(`REG_CTRL, 32'h1B);
            frame(p);
            frame(p);
            `CHK(p, st + mt, "pulse count")
            `CHK(abs_serial_clock_pos, 1'b1, "clock idle")
            `CHK(shaft_position, abs_word(value, st + mt) + off, "abs")
            `CHK(pos_reg_en, 1'b1, "abs pos enable")
        end
        $display("test absolute done");
        finish_test();
    end
endmodule // motor_feedback_interface_bench
